// [srp_pkg.sv]
// Package holding constants of the serial ROM register preload block.
package srp_pkg;

  // --------------------------------------------------------------------------
  // Bus address and map layout
  // --------------------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR     = 7'h50;
  localparam logic [7:0] FUNC_BRIDGE    = 8'h00;
  localparam logic [7:0] FUNC_LINK      = 8'h02;
  localparam logic [7:0] BRIDGE_COUNT   = 8'h20;
  localparam logic [7:0] OFS_FUNC       = 8'h00;
  localparam logic [7:0] OFS_COUNT      = 8'h01;
  localparam logic [7:0] OFS_CMD0       = 8'h02;
  localparam logic [7:0] OFS_CMD1       = 8'h03;
  localparam logic [7:0] OFS_SSVID_LO   = 8'h04;
  localparam logic [7:0] OFS_SSVID_HI   = 8'h05;
  localparam logic [7:0] OFS_SSID_LO    = 8'h06;
  localparam logic [7:0] OFS_SSID_HI    = 8'h07;
  localparam logic [7:0] OFS_LEGACY_0   = 8'h08;
  localparam logic [7:0] OFS_LEGACY_3   = 8'h0B;
  localparam logic [7:0] OFS_SYSC0_F0   = 8'h0C;
  localparam logic [7:0] OFS_SYSC0_F1   = 8'h0D;
  localparam logic [7:0] OFS_SYSC1      = 8'h0E;
  localparam logic [7:0] OFS_SYSC2      = 8'h0F;
  localparam logic [7:0] OFS_SYSC3      = 8'h10;
  localparam logic [7:0] OFS_ROUTE_0    = 8'h11;
  localparam logic [7:0] OFS_LAST       = 8'h12;

  // --------------------------------------------------------------------------
  // Field masks and reset values
  // --------------------------------------------------------------------------
  localparam logic [7:0]  CMD_BYTE_MASK  = 8'hE7;
  localparam logic [7:0]  LEGACY0_MASK   = 8'hFE;
  localparam logic [7:0]  SYSC0_F0_MASK  = 8'h7F;
  localparam logic [7:0]  SYSC0_F1_MASK  = 8'h04;
  localparam logic [7:0]  SYSC1_MASK     = 8'hC0;
  localparam logic [7:0]  SYSC3_MASK     = 8'hFD;
  localparam logic [15:0] CMD_RESET      = 16'h0000;
  localparam logic [15:0] SSID_RESET     = 16'h0000;
  localparam logic [31:0] LEGACY_RESET   = 32'h0000_0001;
  localparam logic [7:0]  SYSC_RESET     = 8'h00;
  localparam logic [15:0] ROUTE_RESET    = 16'h0000;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int CLK_MHZ      = 250;
  localparam int SCL_KHZ      = 100;
  localparam int QUARTER_CYC  = (CLK_MHZ * 1000) / (SCL_KHZ * 4);

endpackage

// [srp_sync.sv]
// Three-stage input synchroniser with second/third stage agreement.
`timescale 1ns/10ps
module srp_sync #(
  parameter logic INIT = 1'b1
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic din,
  output logic      dout
);

  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dout <= INIT;
    end else if (s2 == s3) begin
      dout <= s3;
    end
  end

endmodule

// [srp_i2c_byte.sv]
// Two-wire bus master engine: start, byte send, byte receive with ack, stop.
`timescale 1ns/10ps
module srp_i2c_byte #(
  parameter int QUARTER = srp_pkg::QUARTER_CYC
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       cmd_valid,
  input  wire logic [2:0] cmd_op,
  input  wire logic [7:0] cmd_data,
  input  wire logic       cmd_last,
  output logic            cmd_ready,
  output logic            done,
  output logic            nack,
  output logic [7:0]      rx_data,
  output logic            scl_oe,
  output logic            sda_oe,
  input  wire logic       scl_in,
  input  wire logic       sda_in
);

  // --------------------------------------------------------------------------
  // Operations: 1 start, 2 write byte, 3 read byte, 4 stop.
  // Each bit takes at least four quarter periods; pins are driven low only.
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    SRP_E_IDLE  = 4'h1,
    SRP_E_START = 4'h2,
    SRP_E_BIT   = 4'h4,
    SRP_E_STOP  = 4'h8
  } srp_eng_t;

  srp_eng_t   st;
  logic [15:0] qcnt;
  logic [1:0]  phase;
  logic [3:0]  bitn;
  logic [8:0]  shreg;
  logic        rd;
  logic        tick;

  assign tick      = (qcnt == 16'(QUARTER - 1));
  assign cmd_ready = (st == SRP_E_IDLE);

  always_ff @(posedge clk) begin
    if (sys_rst || st == SRP_E_IDLE || tick) begin
      qcnt <= 16'h0000;
    end else begin
      qcnt <= qcnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st      <= SRP_E_IDLE;
      phase   <= 2'h0;
      bitn    <= 4'h0;
      shreg   <= 9'h000;
      rd      <= 1'b0;
      done    <= 1'b0;
      nack    <= 1'b0;
      rx_data <= 8'h00;
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (st)
        SRP_E_IDLE: begin
          phase <= 2'h0;
          if (cmd_valid) begin
            unique case (cmd_op)
              3'h1: st <= SRP_E_START;
              3'h2: begin
                st    <= SRP_E_BIT;
                rd    <= 1'b0;
                shreg <= {cmd_data, 1'b1};
                bitn  <= 4'h0;
              end
              3'h3: begin
                st    <= SRP_E_BIT;
                rd    <= 1'b1;
                shreg <= {8'hFF, cmd_last};
                bitn  <= 4'h0;
              end
              default: st <= SRP_E_STOP;
            endcase
          end
        end
        SRP_E_START: if (tick) begin
          phase <= phase + 2'h1;
          unique case (phase)
            2'h0: begin
              scl_oe <= 1'b0;
              sda_oe <= 1'b0;
            end
            2'h1: sda_oe <= 1'b1;
            2'h2: scl_oe <= 1'b1;
            default: begin
              st   <= SRP_E_IDLE;
              done <= 1'b1;
            end
          endcase
        end
        SRP_E_BIT: if (tick) begin
          phase <= phase + 2'h1;
          unique case (phase)
            2'h0: sda_oe <= ~shreg[8];
            2'h1: scl_oe <= 1'b0;
            2'h2: begin
              if (scl_in) begin
                shreg <= {shreg[7:0], sda_in};
              end else begin
                phase <= 2'h2;
              end
            end
            default: begin
              scl_oe <= 1'b1;
              bitn   <= bitn + 4'h1;
              if (bitn == 4'h8) begin
                st      <= SRP_E_IDLE;
                done    <= 1'b1;
                sda_oe  <= 1'b0;
                nack    <= ~rd & shreg[0];
                rx_data <= shreg[8:1];
              end
            end
          endcase
        end
        SRP_E_STOP: if (tick) begin
          phase <= phase + 2'h1;
          unique case (phase)
            2'h0: sda_oe <= 1'b1;
            2'h1: scl_oe <= 1'b0;
            2'h2: sda_oe <= 1'b0;
            default: begin
              st   <= SRP_E_IDLE;
              done <= 1'b1;
            end
          endcase
        end
        default: st <= SRP_E_IDLE;
      endcase
    end
  end

endmodule

// [srp_loader.sv]
// Serial ROM register preload: after host reset, reads defaults from an EEPROM.
//
// Function
// - After host reset, load defaults if ROM present.
// - Address EEPROM at slave 1010000 binary.
// - Byte 00h is function indicator, 00h bridge.
// - Byte 01h is section count, 20h here.
// - Bytes 02h,03h load command bits, skip 4:3.
// - Bytes 08h-0Bh load legacy base, low first.
// - Byte 0Ch loads system control 0 bits 6-0.
// - Byte 0Dh bit 2 only, function 1.
// - Byte 0Eh bits 7,6 to system control 1.
// - Byte 0Fh read but never loaded.
// - Byte 10h loads bits 7-2,0, keeps bit 1.
// - Bytes 11h,12h load routing register bytes 0,1.
// - ROM present only when clock line pulled high.
// - Doubleword reads only from reset-time initialisation.
// - Later section begins with indicator 02h.
// - Drive serial clock near 100 kHz, standard mode.
`timescale 1ns/10ps
module srp_loader #(
  parameter int QUARTER = srp_pkg::QUARTER_CYC
) (
  input  wire logic   clk,
  input  wire logic   sys_rst,
  input  wire logic   host_rst,
  input  wire logic   scl_in,
  output logic        scl_out,
  output logic        scl_oe,
  input  wire logic   sda_in,
  output logic        sda_out,
  output logic        sda_oe,
  output logic        load_busy,
  output logic        load_done,
  output logic        load_error,
  output logic [15:0] cmd_f0,
  output logic [15:0] cmd_f1,
  output logic [15:0] subsys_vendor_id,
  output logic [15:0] subsys_id,
  output logic [31:0] legacy_base,
  output logic [7:0]  sysctl0_f0,
  output logic [7:0]  sysctl0_f1,
  output logic [7:0]  sysctl1,
  output logic [7:0]  sysctl3,
  output logic [15:0] multifunction_terminal_routing
);

  // --------------------------------------------------------------------------
  // Input synchronisers and engine
  // --------------------------------------------------------------------------
  logic       scl_s;
  logic       sda_s;
  logic       hrst_s;
  logic       hrst_d;
  logic       e_valid;
  logic [2:0] e_op;
  logic [7:0] e_data;
  logic       e_last;
  logic       e_ready;
  logic       e_done;
  logic       e_nack;
  logic [7:0] e_rx;

  srp_sync u_sync_scl (.clk(clk), .sys_rst(sys_rst), .din(scl_in), .dout(scl_s));
  srp_sync u_sync_sda (.clk(clk), .sys_rst(sys_rst), .din(sda_in), .dout(sda_s));
  // Host reset idles low, so its stages start low and no false falling edge follows reset.
  srp_sync #(.INIT(1'b0)) u_sync_rst (.clk(clk), .sys_rst(sys_rst), .din(host_rst),
                                      .dout(hrst_s));

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  srp_i2c_byte #(.QUARTER(QUARTER)) u_eng (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .cmd_valid (e_valid),
    .cmd_op    (e_op),
    .cmd_data  (e_data),
    .cmd_last  (e_last),
    .cmd_ready (e_ready),
    .done      (e_done),
    .nack      (e_nack),
    .rx_data   (e_rx),
    .scl_oe    (scl_oe),
    .sda_oe    (sda_oe),
    .scl_in    (scl_s),
    .sda_in    (sda_s)
  );

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  typedef enum logic [10:0] {
    SRP_IDLE   = 11'h001,
    SRP_DETECT = 11'h002,
    SRP_ST1    = 11'h004,
    SRP_AW     = 11'h008,
    SRP_OFS    = 11'h010,
    SRP_ST2    = 11'h020,
    SRP_AR     = 11'h040,
    SRP_RD     = 11'h080,
    SRP_STOP   = 11'h100,
    SRP_WAIT   = 11'h200,
    SRP_END    = 11'h400
  } srp_state_t;

  srp_state_t st;
  logic       issued;
  logic [7:0] ofs;
  logic       fail;
  logic       wr_stb;
  logic [7:0] wr_ofs;
  logic [7:0] wr_byte;
  logic       last_byte;

  assign last_byte = (ofs == srp_pkg::OFS_LAST);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hrst_d <= 1'b0;
    end else begin
      hrst_d <= hrst_s;
    end
  end

  always_comb begin
    e_valid = 1'b0;
    e_op    = 3'h0;
    e_data  = 8'h00;
    e_last  = 1'b0;
    if (!issued) begin
      unique case (st)
        SRP_ST1, SRP_ST2: begin
          e_valid = 1'b1;
          e_op    = 3'h1;
        end
        SRP_AW: begin
          e_valid = 1'b1;
          e_op    = 3'h2;
          e_data  = {srp_pkg::SLAVE_ADDR, 1'b0};
        end
        SRP_OFS: begin
          e_valid = 1'b1;
          e_op    = 3'h2;
          e_data  = srp_pkg::OFS_FUNC;
        end
        SRP_AR: begin
          e_valid = 1'b1;
          e_op    = 3'h2;
          e_data  = {srp_pkg::SLAVE_ADDR, 1'b1};
        end
        SRP_RD: begin
          e_valid = 1'b1;
          e_op    = 3'h3;
          e_last  = last_byte;
        end
        SRP_STOP: begin
          e_valid = 1'b1;
          e_op    = 3'h4;
        end
        default: e_valid = 1'b0;
      endcase
    end
  end

  // Only this sequence, started by host reset, ever issues reads.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st         <= SRP_IDLE;
      issued     <= 1'b0;
      ofs        <= 8'h00;
      fail       <= 1'b0;
      load_busy  <= 1'b0;
      load_done  <= 1'b0;
      load_error <= 1'b0;
      wr_stb     <= 1'b0;
      wr_ofs     <= 8'h00;
      wr_byte    <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (e_valid && e_ready) begin
        issued <= 1'b1;
      end
      unique case (st)
        SRP_IDLE: if (hrst_d && !hrst_s) begin
          st         <= SRP_DETECT;
          load_busy  <= 1'b1;
          load_done  <= 1'b0;
          load_error <= 1'b0;
          fail       <= 1'b0;
          ofs        <= 8'h00;
        end
        SRP_DETECT: st <= scl_s ? SRP_ST1 : SRP_END;
        SRP_RD: if (e_done) begin
          issued  <= 1'b0;
          wr_stb  <= 1'b1;
          wr_ofs  <= ofs;
          wr_byte <= e_rx;
          ofs     <= ofs + 8'h01;
          if ((ofs == srp_pkg::OFS_FUNC && e_rx != srp_pkg::FUNC_BRIDGE) ||
              (ofs == srp_pkg::OFS_COUNT && e_rx != srp_pkg::BRIDGE_COUNT)) begin
            fail <= 1'b1;
            st   <= SRP_STOP;
          end else if (last_byte) begin
            st <= SRP_STOP;
          end
        end
        SRP_STOP: if (e_done) begin
          issued <= 1'b0;
          st     <= SRP_END;
        end
        SRP_END: begin
          st         <= SRP_IDLE;
          load_busy  <= 1'b0;
          load_done  <= 1'b1;
          load_error <= fail | ~scl_s;
        end
        default: if (e_done) begin
          issued <= 1'b0;
          if (e_nack) begin
            fail <= 1'b1;
            st   <= SRP_STOP;
          end else begin
            unique case (st)
              SRP_ST1: st <= SRP_AW;
              SRP_AW:  st <= SRP_OFS;
              SRP_OFS: st <= SRP_ST2;
              SRP_ST2: st <= SRP_AR;
              default: st <= SRP_RD;
            endcase
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Register placement; reset values stand until each byte arrives.
  // --------------------------------------------------------------------------
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                       input logic [7:0] msk);
    merge = (old & ~msk) | (nw & msk);
  endfunction

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_f0 <= srp_pkg::CMD_RESET;
      cmd_f1 <= srp_pkg::CMD_RESET;
    end else if (wr_stb && (wr_ofs == srp_pkg::OFS_CMD0 || wr_ofs == srp_pkg::OFS_CMD1)) begin
      if (wr_ofs == srp_pkg::OFS_CMD0) begin
        cmd_f0[8]   <= wr_byte[7];
        cmd_f0[6:5] <= wr_byte[6:5];
        cmd_f0[2:0] <= wr_byte[2:0];
      end else begin
        cmd_f1[8]   <= wr_byte[7];
        cmd_f1[6:5] <= wr_byte[6:5];
        cmd_f1[2:0] <= wr_byte[2:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      subsys_vendor_id <= srp_pkg::SSID_RESET;
      subsys_id        <= srp_pkg::SSID_RESET;
    end else if (wr_stb) begin
      unique case (wr_ofs)
        srp_pkg::OFS_SSVID_LO: subsys_vendor_id[7:0]  <= wr_byte;
        srp_pkg::OFS_SSVID_HI: subsys_vendor_id[15:8] <= wr_byte;
        srp_pkg::OFS_SSID_LO:  subsys_id[7:0]         <= wr_byte;
        srp_pkg::OFS_SSID_HI:  subsys_id[15:8]        <= wr_byte;
        default: ;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_legacy
      localparam logic [7:0] MSK = (gi == 0) ? srp_pkg::LEGACY0_MASK : 8'hFF;
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          legacy_base[gi*8 +: 8] <= srp_pkg::LEGACY_RESET[gi*8 +: 8];
        end else if (wr_stb && wr_ofs == srp_pkg::OFS_LEGACY_0 + 8'(gi)) begin
          legacy_base[gi*8 +: 8] <= merge(legacy_base[gi*8 +: 8], wr_byte, MSK);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sysctl0_f0 <= srp_pkg::SYSC_RESET;
      sysctl0_f1 <= srp_pkg::SYSC_RESET;
      sysctl1    <= srp_pkg::SYSC_RESET;
      sysctl3    <= srp_pkg::SYSC_RESET;
    end else if (wr_stb) begin
      unique case (wr_ofs)
        srp_pkg::OFS_SYSC0_F0: sysctl0_f0 <= merge(sysctl0_f0, wr_byte, srp_pkg::SYSC0_F0_MASK);
        srp_pkg::OFS_SYSC0_F1: sysctl0_f1 <= merge(sysctl0_f1, wr_byte, srp_pkg::SYSC0_F1_MASK);
        srp_pkg::OFS_SYSC1:    sysctl1 <= merge(sysctl1, wr_byte, srp_pkg::SYSC1_MASK);
        srp_pkg::OFS_SYSC3:    sysctl3 <= merge(sysctl3, wr_byte, srp_pkg::SYSC3_MASK);
        default: ; // Byte 0Fh falls here and is dropped.
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      multifunction_terminal_routing <= srp_pkg::ROUTE_RESET;
    end else if (wr_stb && wr_ofs == srp_pkg::OFS_ROUTE_0) begin
      multifunction_terminal_routing[7:0] <= wr_byte;
    end else if (wr_stb && wr_ofs == srp_pkg::OFS_LAST) begin
      multifunction_terminal_routing[15:8] <= wr_byte;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence s_addr_sent;
    st == SRP_AW && e_valid && e_ready;
  endsequence

  start_no_scl_a: assert property (@(posedge clk) disable iff (sys_rst)
    st == SRP_DETECT && !scl_s |=> st == SRP_END)
    else $error("load started without pulled-up clock");
  addr_value_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_addr_sent |-> e_data == 8'hA0)
    else $error("wrong slave address");
  nack_abort_a: assert property (@(posedge clk) disable iff (sys_rst)
    st == SRP_AW && e_done && e_nack |=> st == SRP_STOP && fail)
    else $error("nack did not abort");
  bad_func_a: assert property (@(posedge clk) disable iff (sys_rst)
    st == SRP_RD && e_done && ofs == 8'h00 && e_rx != 8'h00 |=> fail)
    else $error("bad indicator accepted");
  bad_count_a: assert property (@(posedge clk) disable iff (sys_rst)
    st == SRP_RD && e_done && ofs == 8'h01 && e_rx != 8'h20 |=> fail)
    else $error("bad count accepted");
  cmd_load_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_stb && wr_ofs == 8'h02 |=> cmd_f0[8] == $past(wr_byte[7])
      && cmd_f0[2:0] == $past(wr_byte[2:0]) && cmd_f0[4:3] == $past(cmd_f0[4:3]))
    else $error("command byte misplaced");
  sysc3_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_stb && wr_ofs == 8'h10 |=> sysctl3[1] == $past(sysctl3[1])
      && sysctl3[0] == $past(wr_byte[0]))
    else $error("system control 3 merge wrong");
  sysc1_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_stb && wr_ofs == 8'h0E |=> sysctl1 == {$past(wr_byte[7:6]), $past(sysctl1[5:0])})
    else $error("system control 1 merge wrong");
  reserved_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_stb && wr_ofs == 8'h0F |=> $stable(sysctl1) && $stable(sysctl3))
    else $error("reserved byte loaded");
  route_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_stb && wr_ofs == 8'h12 |=> multifunction_terminal_routing[15:8] == $past(wr_byte))
    else $error("routing byte 1 wrong");
  legacy_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_stb && wr_ofs == 8'h08 |=> legacy_base[0] == $past(legacy_base[0]))
    else $error("legacy bit 0 loaded");

endmodule

// [srp_eeprom_model.sv]
// Behavioural two-wire EEPROM slave that answers sequential reads.
`timescale 1ns/10ps
module srp_eeprom_model (
  input  wire logic  scl,
  input  wire logic  sda,
  input  wire logic  refuse,
  output logic       sda_drive,
  output logic [7:0] addr_seen
);
  logic [7:0] mem [0:255];
  logic [7:0] sh;
  logic [7:0] ptr;
  logic [7:0] tx_byte;
  logic [3:0] cnt;
  logic [1:0] phase;
  logic       tx;
  logic       go_tx;

  initial begin
    sda_drive = 1'b0;
    addr_seen = 8'h00;
    cnt = 4'h0;
    tx = 1'b0;
    go_tx = 1'b0;
    phase = 2'h0;
  end

  // A start condition restarts the byte framing.
  always @(negedge sda) begin
    if (scl) begin
      cnt = 4'h0;
      phase = 2'h0;
      tx = 1'b0;
      go_tx = 1'b0;
    end
  end

  always @(posedge scl) begin
    if (cnt < 4'h8 && !tx) sh = {sh[6:0], sda};
    if (cnt == 4'h8 && tx) go_tx = !sda;
    cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
  end

  always @(negedge scl) begin
    sda_drive = 1'b0;
    if (cnt == 4'h8 && !tx) begin
      if (phase == 2'h0) begin
        addr_seen = sh;
        sda_drive = (sh[7:1] == 7'h50) && !refuse;
        go_tx = sda_drive && sh[0];
        phase = 2'h1;
      end else if (phase == 2'h1) begin
        ptr = sh;
        sda_drive = 1'b1;
        phase = 2'h2;
      end
    end else if (cnt == 4'h0) begin
      tx = go_tx;
      if (tx) begin
        tx_byte = mem[ptr];
        ptr = ptr + 8'h01;
      end
    end
    if (tx && cnt < 4'h8) sda_drive = !tx_byte[3'h7 - cnt[2:0]];
  end
endmodule

// [tb_srp_loader.sv]
// Testbench of the serial ROM register preload block.
`timescale 1ns/10ps
module tb_srp_loader;
  logic        clk;
  logic        sys_rst;
  logic        host_rst;
  logic        present;
  logic        refuse;
  logic        scl_oe;
  logic        sda_oe;
  logic        sda_drive;
  logic [7:0]  addr_seen;
  logic        load_busy;
  logic        load_done;
  logic        load_error;
  logic [15:0] cmd_f0;
  logic [15:0] cmd_f1;
  logic [15:0] subsys_vendor_id;
  logic [15:0] subsys_id;
  logic [31:0] legacy_base;
  logic [7:0]  sysctl0_f0;
  logic [7:0]  sysctl0_f1;
  logic [7:0]  sysctl1;
  logic [7:0]  sysctl3;
  logic [15:0] multifunction_terminal_routing;
  int          bad_count;
  int          checks;
  int          cyc;
  wire         scl_w = present ? !scl_oe : 1'b0;
  wire         sda_w = !(sda_oe || sda_drive);

  srp_loader #(.QUARTER(4)) srp_loader_i (
    .clk(clk), .sys_rst(sys_rst), .host_rst(host_rst), .scl_in(scl_w), .scl_out(),
    .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe), .load_busy(load_busy),
    .load_done(load_done), .load_error(load_error), .cmd_f0(cmd_f0), .cmd_f1(cmd_f1),
    .subsys_vendor_id(subsys_vendor_id), .subsys_id(subsys_id), .legacy_base(legacy_base),
    .sysctl0_f0(sysctl0_f0), .sysctl0_f1(sysctl0_f1), .sysctl1(sysctl1), .sysctl3(sysctl3),
    .multifunction_terminal_routing(multifunction_terminal_routing));

  srp_eeprom_model srp_eeprom_model_i (
    .scl(scl_w), .sda(sda_w), .refuse(refuse), .sda_drive(sda_drive), .addr_seen(addr_seen));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      summarize();
    end
  end

  function automatic logic [7:0] b(input int k);
    return 8'h3C + 8'(k) * 8'h17;
  endfunction

  function automatic logic [15:0] cmd_of(input logic [7:0] x);
    return {7'h00, x[7], 1'b0, x[6:5], 2'b00, x[2:0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Pulses the host reset and waits, bounded, for the load to finish.
  task automatic run_load(input string name, input logic err);
    int n;
    host_rst <= 1'b1;
    repeat (8) @(posedge clk);
    host_rst <= 1'b0;
    repeat (12) @(posedge clk);
    n = 0;
    @(negedge clk);
    chk(load_busy, present);
    while (load_done !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk(load_done, 1'b1);
    chk(load_busy, 1'b0);
    chk(load_error, err);
    $display("test %s done", name);
  endtask

  task automatic check_regs(input bit ld);
    chk(cmd_f0, ld ? cmd_of(b(2)) : 16'h0000);
    chk(cmd_f1, ld ? cmd_of(b(3)) : 16'h0000);
    chk(subsys_vendor_id, ld ? {b(5), b(4)} : 16'h0000);
    chk(subsys_id, ld ? {b(7), b(6)} : 16'h0000);
    chk(legacy_base, ld ? {b(11), b(10), b(9), b(8) | 8'h01} : 32'h00000001);
    chk(sysctl0_f0, ld ? b(12) & 8'h7F : 8'h00);
    chk(sysctl0_f1, ld ? b(13) & 8'h04 : 8'h00);
    chk(sysctl1, ld ? b(14) & 8'hC0 : 8'h00);
    chk(sysctl3, ld ? b(16) & 8'hFD : 8'h00);
    chk(multifunction_terminal_routing, ld ? {b(18), b(17)} : 16'h0000);
  endtask

  task automatic summarize;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    host_rst = 1'b0;
    present = 1'b0;
    refuse = 1'b0;
    bad_count = 0;
    checks = 0;
    cyc = 0;
    for (int k = 0; k < 256; k++) srp_eeprom_model_i.mem[k] = b(k);
    srp_eeprom_model_i.mem[0] = 8'h00;
    srp_eeprom_model_i.mem[1] = 8'h20;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    run_load("absent", 1'b1);
    check_regs(1'b0);
    present <= 1'b1;
    run_load("full", 1'b0);
    check_regs(1'b1);
    chk(addr_seen, 8'hA1);
    refuse <= 1'b1;
    run_load("refused", 1'b1);
    check_regs(1'b1);
    refuse <= 1'b0;
    srp_eeprom_model_i.mem[0] = 8'h02;
    run_load("indicator", 1'b1);
    check_regs(1'b1);
    srp_eeprom_model_i.mem[0] = 8'h00;
    srp_eeprom_model_i.mem[1] = 8'h1F;
    run_load("count", 1'b1);
    check_regs(1'b1);
    summarize();
  end
endmodule
